/* File: imsf_pkg.sv */
/*
 * Shared constants of the two-wire memory slave front end and its bus master.
 * Assumes a 50 MHz system clock on both ends.
 */
package imsf_pkg;
	localparam logic [3:0] CTRL_CODE = 4'hA;
	localparam int ADDR_W = 13;
	localparam int PAGE_W = 5;
	localparam int CLK_MHZ = 50;
	localparam int POR_MAX_US = 75;
	// longest time; 75 us at 50 MHz is a whole 3750 cycles, so nothing is rounded
	localparam int POR_CYC = (POR_MAX_US * CLK_MHZ) / 1;
	localparam int WCYC_DEF = 1000;
	localparam int QTR_DEF = 63;
	localparam int AXI_AW = 4;
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam int CMD_START_BIT = 8;
	localparam int CMD_STOP_BIT = 9;
	localparam int CMD_RD_BIT = 10;
	localparam int CMD_ACK_BIT = 11;
	localparam logic [11:0] CMD_RST = 12'h000;
	localparam int STAT_BUSY_BIT = 8;
	localparam int STAT_NACK_BIT = 9;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : imsf_pkg

/* File: imsf_if.sv */
/*
 * Two-wire link between the bus master and the memory slave front end.
 * Both wires are open drain; a pull-up is modelled by the wired-AND below.
 */
`timescale 1ns/1ps
interface imsf_if;
	logic h_scl_o;
	logic h_scl_oe;
	logic h_sda_o;
	logic h_sda_oe;
	logic d_sda_o;
	logic d_sda_oe;
	logic scl;
	logic sda;

	assign scl = !(h_scl_oe && !h_scl_o);
	assign sda = !(h_sda_oe && !h_sda_o) && !(d_sda_oe && !d_sda_o);

	modport dev(input scl, input sda, output d_sda_o, output d_sda_oe);
	modport host(input scl, input sda, output h_scl_o, output h_scl_oe, output h_sda_o,
		output h_sda_oe);
endinterface : imsf_if

/* File: imsf_dev.sv */
/*
 * Slave end of the two-wire memory front end: start/stop detection, byte shifting,
 * control byte decode, addressing, page buffer and write-cycle timing.
 * Assumes a memory array on the user side with combinational read data.
 */
`timescale 1ns/1ps
module imsf_dev #(
	parameter int WCYC = imsf_pkg::WCYC_DEF
) (
	input wire logic clk_sys_i, // system clock
	input wire logic rst_i, // async reset, active high
	imsf_if.dev bus, // two-wire link
	input wire logic select_pin_lsb_i, // select strap, lsb
	input wire logic select_pin_mid_i, // select strap, middle
	input wire logic select_pin_msb_i, // select strap, msb
	input wire logic write_protect_i, // high inhibits writes
	input wire logic [7:0] mem_rdata_i, // array data at mem_addr_o
	output logic [12:0] mem_addr_o, // array address
	output logic [7:0] mem_wdata_o, // array write data
	output logic mem_wr_o, // array write strobe
	output logic write_busy_o, // internal write cycle running
	output logic bus_busy_o, // between start and stop
	output logic ready_o // power-on reset over
);
	typedef enum logic [4:0] {
		D_IDLE = 5'h01,
		D_RX = 5'h02,
		D_ACK = 5'h04,
		D_TX = 5'h08,
		D_MACK = 5'h10
	} imsf_dst_t;

	typedef struct packed {
		logic [2:0] scl_q;
		logic [2:0] sda_q;
		logic [3:0] pin_q1;
		logic [3:0] pin_q2;
		logic [11:0] por_cnt;
		logic por_done;
		imsf_dst_t st;
		logic [3:0] bit_cnt;
		logic [7:0] sh;
		logic [1:0] byte_idx;
		logic rd;
		logic mack;
		logic sda_oe;
		logic bbusy;
		logic [imsf_pkg::ADDR_W-1:0] ptr;
		logic [31:0][7:0] pbuf;
		logic [31:0] pvalid;
		logic busy;
		logic [15:0] wcnt;
		logic mem_wr;
		logic [12:0] mem_addr;
		logic [7:0] mem_wdata;
	} imsf_dev_t;

	localparam logic [11:0] POR_LAST = 12'(imsf_pkg::POR_CYC - 1);
	localparam logic [15:0] WC_LAST = 16'(WCYC - 1);

	imsf_dev_t s_r;
	imsf_dev_t s_nxt;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic sel_match;

	// only second-stage and later samples feed the edge logic
	assign scl_rise = s_r.scl_q[1] & ~s_r.scl_q[2];
	assign scl_fall = ~s_r.scl_q[1] & s_r.scl_q[2];
	assign start_det = s_r.scl_q[1] & s_r.scl_q[2] & s_r.sda_q[2] & ~s_r.sda_q[1];
	assign stop_det = s_r.scl_q[1] & s_r.scl_q[2] & ~s_r.sda_q[2] & s_r.sda_q[1];
	assign sel_match = (s_r.sh[7:4] == imsf_pkg::CTRL_CODE)
		&& (s_r.sh[3:1] == s_r.pin_q2[2:0])
		&& !s_r.busy;

	always_comb begin
		s_nxt = s_r;
		s_nxt.scl_q = {s_r.scl_q[1:0], bus.scl};
		s_nxt.sda_q = {s_r.sda_q[1:0], bus.sda};
		s_nxt.pin_q1 = {write_protect_i, select_pin_msb_i, select_pin_mid_i, select_pin_lsb_i};
		s_nxt.pin_q2 = s_r.pin_q1;
		s_nxt.mem_wr = 1'b0;
		if (!s_r.por_done) begin
			s_nxt.por_cnt = s_r.por_cnt + 12'h001;
			if (s_r.por_cnt == POR_LAST) begin
				s_nxt.por_done = 1'b1;
			end
		end
		// write cycle: first 32 cycles drain the page buffer, the rest is dead time
		if (s_r.busy) begin
			s_nxt.wcnt = s_r.wcnt + 16'h0001;
			if (s_r.wcnt[15:5] == 11'h000 && s_r.pvalid[s_r.wcnt[4:0]]) begin
				s_nxt.mem_wr = 1'b1;
				s_nxt.mem_addr = {s_r.ptr[12:5], s_r.wcnt[4:0]};
				s_nxt.mem_wdata = s_r.pbuf[s_r.wcnt[4:0]];
			end
			if (s_r.wcnt == WC_LAST) begin
				s_nxt.busy = 1'b0;
				s_nxt.pvalid = 32'h0000_0000;
			end
		end else begin
			s_nxt.mem_addr = s_r.ptr;
		end
		if (!s_r.por_done) begin
			s_nxt.st = D_IDLE;
		end else if (start_det) begin
			s_nxt.st = D_RX;
			s_nxt.bit_cnt = 4'h0;
			s_nxt.byte_idx = 2'h0;
			s_nxt.sda_oe = 1'b0;
			s_nxt.bbusy = 1'b1;
		end else if (stop_det) begin
			s_nxt.st = D_IDLE;
			s_nxt.sda_oe = 1'b0;
			s_nxt.bbusy = 1'b0;
			s_nxt.byte_idx = 2'h0;
			if (!s_r.rd && s_r.byte_idx == 2'h3 && s_r.pvalid != 32'h0000_0000) begin
				// protect level taken only here; the cycle ignores it afterwards
				if (!s_r.pin_q2[3]) begin
					s_nxt.busy = 1'b1;
					s_nxt.wcnt = 16'h0000;
				end else begin
					s_nxt.pvalid = 32'h0000_0000;
				end
			end
		end else begin
			unique case (s_r.st)
				D_IDLE: begin
				end
				D_RX: begin
					if (scl_rise) begin
						s_nxt.sh = {s_r.sh[6:0], s_r.sda_q[1]};
						s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
					end else if (scl_fall && s_r.bit_cnt == 4'h8) begin
						s_nxt.bit_cnt = 4'h0;
						s_nxt.st = D_ACK;
						s_nxt.sda_oe = 1'b1;
						case (s_r.byte_idx)
							2'h0: begin
								if (sel_match) begin
									s_nxt.rd = s_r.sh[0];
									s_nxt.byte_idx = 2'h1;
									if (!s_r.sh[0]) begin
										s_nxt.pvalid = 32'h0000_0000;
									end
								end else begin
									s_nxt.st = D_IDLE;
									s_nxt.sda_oe = 1'b0;
								end
							end
							2'h1: begin
								s_nxt.ptr[12:8] = s_r.sh[4:0];
								s_nxt.byte_idx = 2'h2;
							end
							2'h2: begin
								s_nxt.ptr[7:0] = s_r.sh;
								s_nxt.byte_idx = 2'h3;
							end
							default: begin
								// no byte limit: later bytes overwrite earlier ones
								s_nxt.pbuf[s_r.ptr[4:0]] = s_r.sh;
								s_nxt.pvalid[s_r.ptr[4:0]] = 1'b1;
								s_nxt.ptr[4:0] = s_r.ptr[4:0] + 5'h01;
							end
						endcase
					end
				end
				D_ACK, D_MACK: begin
					if (scl_rise) begin
						s_nxt.mack = ~s_r.sda_q[1];
					end else if (scl_fall) begin
						if (s_r.st == D_ACK ? s_r.rd : s_r.mack) begin
							s_nxt.st = D_TX;
							s_nxt.sh = mem_rdata_i;
							s_nxt.sda_oe = ~mem_rdata_i[7];
							s_nxt.ptr = s_r.ptr + 13'h0001;
							s_nxt.bit_cnt = 4'h0;
						end else if (s_r.st == D_ACK) begin
							s_nxt.st = D_RX;
							s_nxt.sda_oe = 1'b0;
						end else begin
							s_nxt.st = D_IDLE;
							s_nxt.sda_oe = 1'b0;
						end
					end
				end
				D_TX: begin
					if (scl_fall) begin
						if (s_r.bit_cnt == 4'h7) begin
							s_nxt.st = D_MACK;
							s_nxt.sda_oe = 1'b0;
						end else begin
							s_nxt.sh = {s_r.sh[6:0], 1'b0};
							s_nxt.sda_oe = ~s_r.sh[6];
							s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.st <= D_IDLE;
			s_r.scl_q <= 3'h7;
			s_r.sda_q <= 3'h7;
		end else begin
			s_r <= s_nxt;
		end
	end

	// the slave never starts or stops a frame; it only pulls data low
	assign bus.d_sda_o = 1'b0;
	assign bus.d_sda_oe = s_r.sda_oe;
	assign mem_addr_o = s_r.mem_addr;
	assign mem_wdata_o = s_r.mem_wdata;
	assign mem_wr_o = s_r.mem_wr;
	assign write_busy_o = s_r.busy;
	assign bus_busy_o = s_r.bbusy;
	assign ready_o = s_r.por_done;
endmodule : imsf_dev

/* File: imsf_host.sv */
/*
 * Bus master end: AXI4-Lite command/status registers and a byte engine that
 * makes start, eight bits plus acknowledge, and stop on the two-wire link.
 * Assumes software sequences control, address and data bytes one command each.
 */
`timescale 1ns/1ps
module imsf_host #(
	parameter int QTR_CYC = imsf_pkg::QTR_DEF
) (
	input wire logic clk_sys_i, // system clock
	input wire logic rst_i, // async reset, active high
	imsf_if.host bus, // two-wire link
	input wire logic [imsf_pkg::AXI_AW-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // byte lanes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [imsf_pkg::AXI_AW-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready // read data ready
);
	typedef enum logic [3:0] {
		H_IDLE = 4'h1,
		H_START = 4'h2,
		H_BITS = 4'h4,
		H_STOP = 4'h8
	} imsf_hst_t;

	typedef struct packed {
		logic [1:0] sda_q;
		imsf_hst_t st;
		logic [1:0] q;
		logic [7:0] div;
		logic [3:0] bit_cnt;
		logic [8:0] tx;
		logic [8:0] rx;
		logic [11:0] cmd;
		logic [7:0] rx_data;
		logic nack;
		logic scl_oe;
		logic sda_oe;
		logic aw_got;
		logic w_got;
		logic [imsf_pkg::AXI_AW-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} imsf_host_t;

	localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

	imsf_host_t s_r;
	imsf_host_t s_nxt;

	always_comb begin
		logic [11:0] c;
		logic tick;
		c = s_r.cmd;
		tick = (s_r.div == QTR_LAST);
		s_nxt = s_r;
		s_nxt.sda_q = {s_r.sda_q[0], bus.sda};
		if (s_r.st != H_IDLE) begin
			s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
		end
		if (tick) begin
			s_nxt.q = s_r.q + 2'h1;
			unique case (s_r.st)
				H_IDLE: begin
				end
				H_START: begin
					// data moves only with the clock low, except the start edge itself
					unique case (s_r.q)
						2'h0: s_nxt.sda_oe = 1'b0;
						2'h1: s_nxt.scl_oe = 1'b0;
						2'h2: s_nxt.sda_oe = 1'b1;
						default: begin
							s_nxt.scl_oe = 1'b1;
							s_nxt.st = H_BITS;
						end
					endcase
				end
				H_BITS: begin
					unique case (s_r.q)
						2'h0: s_nxt.sda_oe = ~s_r.tx[8];
						2'h1: s_nxt.scl_oe = 1'b0;
						2'h2: s_nxt.rx = {s_r.rx[7:0], s_r.sda_q[1]};
						default: begin
							s_nxt.scl_oe = 1'b1;
							s_nxt.tx = {s_r.tx[7:0], 1'b1};
							s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
							if (s_r.bit_cnt == 4'h8) begin
								s_nxt.rx_data = s_r.rx[8:1];
								s_nxt.nack = s_r.rx[0];
								s_nxt.st = s_r.cmd[imsf_pkg::CMD_STOP_BIT] ? H_STOP : H_IDLE;
							end
						end
					endcase
				end
				H_STOP: begin
					unique case (s_r.q)
						2'h0: s_nxt.sda_oe = 1'b1;
						2'h1: s_nxt.scl_oe = 1'b0;
						2'h2: s_nxt.sda_oe = 1'b0;
						default: s_nxt.st = H_IDLE;
					endcase
				end
			endcase
		end
		if (s_r.awready && s_axi_awvalid) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_r.wready && s_axi_wvalid) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = imsf_pkg::RESP_OKAY;
			if (s_r.awaddr == imsf_pkg::REG_CMD) begin
				// a command written while a byte is moving is dropped
				if (s_r.st == H_IDLE) begin
					if (s_r.wstrb[0]) begin
						c[7:0] = s_r.wdata[7:0];
					end
					if (s_r.wstrb[1]) begin
						c[11:8] = s_r.wdata[11:8];
					end
					s_nxt.cmd = c;
					// software builds control, address and data bytes; any count allowed
					s_nxt.st = c[imsf_pkg::CMD_START_BIT] ? H_START : H_BITS;
					s_nxt.tx = c[imsf_pkg::CMD_RD_BIT] ? {8'hFF, c[imsf_pkg::CMD_ACK_BIT]}
						: {c[7:0], 1'b1};
					s_nxt.q = 2'h0;
					s_nxt.div = 8'h00;
					s_nxt.bit_cnt = 4'h0;
				end
			end else if (s_r.awaddr != imsf_pkg::REG_STAT) begin
				s_nxt.bresp = imsf_pkg::RESP_SLVERR;
			end
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_r.arready && s_axi_arvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = imsf_pkg::RESP_OKAY;
			s_nxt.rdata = 32'h0000_0000;
			if (s_axi_araddr == imsf_pkg::REG_CMD) begin
				s_nxt.rdata[11:0] = s_r.cmd;
			end else if (s_axi_araddr == imsf_pkg::REG_STAT) begin
				s_nxt.rdata[7:0] = s_r.rx_data;
				s_nxt.rdata[imsf_pkg::STAT_BUSY_BIT] = (s_r.st != H_IDLE);
				s_nxt.rdata[imsf_pkg::STAT_NACK_BIT] = s_r.nack;
			end else begin
				s_nxt.rresp = imsf_pkg::RESP_SLVERR;
			end
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			s_r <= '0;
			s_r.st <= H_IDLE;
			s_r.sda_q <= 2'h3;
			s_r.cmd <= imsf_pkg::CMD_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign bus.h_scl_o = 1'b0;
	assign bus.h_scl_oe = s_r.scl_oe;
	assign bus.h_sda_o = 1'b0;
	assign bus.h_sda_oe = s_r.sda_oe;
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rvalid = s_r.rvalid;
endmodule : imsf_host

/* File: imsf_properties.sv */
/*
 * Link checker for the two-wire path between host and memory front end.
 * Assumes idle-high wired-AND lines and framing that starts at a START.
 */
`timescale 1ns/1ps
module imsf_properties (
	input wire logic clk_sys_i, // system clock
	input wire logic rst_i, // async reset
	input wire logic h_scl_o, // host clock level
	input wire logic h_scl_oe, // host clock pull
	input wire logic h_sda_o, // host data level
	input wire logic h_sda_oe, // host data pull
	input wire logic d_sda_o, // device data level
	input wire logic d_sda_oe, // device data pull
	input wire logic scl, // clock wire
	input wire logic sda // data wire
);
	logic scl_r, sda_r, ack_r, rw_r, miss_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r, byte_r;
	wire start_w = scl && scl_r && sda_r && !sda;
	wire stop_w = scl && scl_r && !sda_r && sda;
	wire rise_w = scl && !scl_r;

	// frame tracker; idle counts as released until the first start
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			{scl_r, sda_r, miss_r} <= 3'h7;
			{ack_r, rw_r, bit_r, sh_r, byte_r} <= '0;
		end else begin
			scl_r <= scl;
			sda_r <= sda;
			if (start_w) begin
				{ack_r, bit_r, byte_r, miss_r} <= '0;
			end else if (stop_w) begin
				miss_r <= 1'b1;
			end else if (rise_w && bit_r == 4'h8) begin
				bit_r <= 4'h0;
				byte_r <= (byte_r == 8'hFF) ? byte_r : byte_r + 8'h01;
				if (byte_r == 8'h00) begin
					ack_r <= !sda;
					rw_r <= sh_r[0];
					miss_r <= sda;
				end
			end else if (rise_w) begin
				bit_r <= bit_r + 4'h1;
				sh_r <= {sh_r[6:0], sda};
			end
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	sequence s_ninth;
		rise_w && bit_r == 4'h8;
	endsequence
	property p_open_drain;
		!h_scl_o && !h_sda_o && !d_sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	property p_dev_pull;
		$rose(d_sda_oe) |-> !scl;
	endproperty
	a_dev_pull: assert property (p_dev_pull) else $error("device pulls with clock high");
	property p_dev_hold;
		scl && scl_r |-> $stable(d_sda_oe);
	endproperty
	a_dev_hold: assert property (p_dev_hold) else $error("device data moves in high");
	property p_host_step;
		$changed(h_sda_oe) |-> $stable(h_scl_oe);
	endproperty
	a_host_step: assert property (p_host_step) else $error("host moves both wires");
	property p_frame;
		stop_w |-> bit_r == 4'h1;
	endproperty
	a_frame: assert property (p_frame) else $error("stop off a byte boundary");
	property p_code;
		s_ninth ##0 (byte_r == 8'h00 && sh_r[7:4] != imsf_pkg::CTRL_CODE) |-> !d_sda_oe;
	endproperty
	a_code: assert property (p_code) else $error("foreign code acknowledged");
	property p_idle;
		miss_r |-> !d_sda_oe;
	endproperty
	a_idle: assert property (p_idle) else $error("device drives while idle");
	property p_ack_all;
		s_ninth ##0 (byte_r != 8'h00 && ack_r && !rw_r) |-> !sda;
	endproperty
	a_ack_all: assert property (p_ack_all) else $error("write byte not acknowledged");
endmodule : imsf_properties

/* File: i2c_memory_slave_frontend_bench.sv */
/*
 * Self-checking bench: host and memory front end joined by the link.
 * Assumes software-style byte commands through the host registers.
 */
`timescale 1ns/1ps
module i2c_memory_slave_frontend_bench;
	localparam logic [11:0] F_S = 12'h001 << imsf_pkg::CMD_START_BIT;
	localparam logic [11:0] F_P = 12'h001 << imsf_pkg::CMD_STOP_BIT;
	localparam logic [11:0] F_RD = 12'h001 << imsf_pkg::CMD_RD_BIT;
	localparam logic [11:0] F_K = 12'h001 << imsf_pkg::CMD_ACK_BIT;
	// nack bit, control byte; straps are 101
	localparam logic [8:0] ROWS [7] = '{9'h0AA, 9'h1BA, 9'h1A2, 9'h1A8, 9'h1AE, 9'h12A, 9'h1EA};
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] sel = 3'h5;
	logic wp = 1'b0;
	logic [7:0] mem [0:8191];
	logic [12:0] ma;
	logic [7:0] mwd;
	logic mwr, wbusy, bbusy, rdy;
	logic [3:0] awa = 4'h0, ara = 4'h0;
	logic [31:0] wd = 32'h0, rd;
	logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
	logic awr, wr, bv, arr, rv;
	logic [1:0] bresp, rresp;
	int n_fail = 0, checked = 0, n_wr = 0;
	wire [7:0] mrd = mem[ma];

	always #10 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		if (mwr) begin
			mem[ma] <= mwd;
			n_wr <= n_wr + 1;
		end
	end

	imsf_if link ();
	imsf_dev #(.WCYC(2000)) imsf_dev_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(link),
		.select_pin_lsb_i(sel[0]), .select_pin_mid_i(sel[1]), .select_pin_msb_i(sel[2]),
		.write_protect_i(wp), .mem_rdata_i(mrd), .mem_addr_o(ma), .mem_wdata_o(mwd),
		.mem_wr_o(mwr), .write_busy_o(wbusy), .bus_busy_o(bbusy), .ready_o(rdy));
	// short quarter keeps a byte near 300 cycles
	imsf_host #(.QTR_CYC(8)) imsf_host_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .bus(link),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rre));
	imsf_properties imsf_properties_i (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
		.h_scl_o(link.h_scl_o), .h_scl_oe(link.h_scl_oe), .h_sda_o(link.h_sda_o),
		.h_sda_oe(link.h_sda_oe), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
		.scl(link.scl), .sda(link.sda));

	function automatic logic [7:0] pat(input logic [12:0] a);
		return a[7:0] ^ a[12:5];
	endfunction : pat
	task automatic tally_and_finish;
		if (n_fail == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("FAIL %0t %s", $time, m);
		end
	endtask : chk
	task automatic hang;
		chk(1'b0, "timeout");
		tally_and_finish();
	endtask : hang
	// a leading edge keeps strobes from being lowered and raised in one step
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_sys_i);
		awa <= a;
		wd <= d;
		{awv, wv, bre} <= 3'h7;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			n++;
			if (n > 200) hang();
		end while (bv !== 1'b1);
		bre <= 1'b0;
		r = bresp;
	endtask : axi_wr
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk_sys_i);
		ara <= a;
		{arv, rre} <= 2'h3;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			if (arv && arr) arv <= 1'b0;
			n++;
			if (n > 200) hang();
		end while (rv !== 1'b1);
		rre <= 1'b0;
		d = rd;
		r = rresp;
	endtask : axi_rd
	task automatic cmd(input logic [11:0] c, output logic [31:0] st);
		logic [1:0] r;
		int n;
		axi_wr(imsf_pkg::REG_CMD, {20'h00000, c}, r);
		chk(r === imsf_pkg::RESP_OKAY, "command refused");
		n = 0;
		do begin
			axi_rd(imsf_pkg::REG_STAT, st, r);
			n++;
			if (n > 3000) hang();
		end while (st[imsf_pkg::STAT_BUSY_BIT] !== 1'b0);
	endtask : cmd
	task automatic send(input logic [11:0] c, input logic nack);
		logic [31:0] st;
		cmd(c, st);
		chk(st[imsf_pkg::STAT_NACK_BIT] === nack, "acknowledge level");
	endtask : send
	task automatic wait_quiet(input logic wc);
		int n;
		n = 0;
		while (bbusy !== 1'b0 || (wc && wbusy !== 1'b0)) begin
			@(posedge clk_sys_i);
			n++;
			if (n > 5000) hang();
		end
	endtask : wait_quiet

	initial begin
		int n, w;
		logic [31:0] st;
		logic [1:0] r;
		for (int i = 0; i < 8192; i++) mem[i] = pat(13'(i));
		repeat (2) @(posedge clk_sys_i);
		chk(rdy === 1'b0 && bbusy === 1'b0 && link.sda === 1'b1, "reset state");
		rst_i <= 1'b0;
		n = 0;
		while (rdy !== 1'b1) begin
			@(posedge clk_sys_i);
			n++;
			if (n > 5000) hang();
		end
		chk(n > 10 && n <= imsf_pkg::POR_CYC + 2, "power-on time");
		axi_wr(4'h8, 32'h0, r);
		chk(r === imsf_pkg::RESP_SLVERR, "unmapped write");
		axi_rd(4'hC, st, r);
		chk(r === imsf_pkg::RESP_SLVERR && st === 32'h0, "unmapped read");
		for (int i = 0; i < 7; i++) send(F_S | F_P | {4'h0, ROWS[i][7:0]}, ROWS[i][8]);
		// 101 reads the same both ways, so an asymmetric strap exposes a swapped order
		sel <= 3'h6;
		send(F_S | F_P | 12'h0AC, 1'b0);
		send(F_S | F_P | 12'h0A6, 1'b1);
		sel <= 3'h5;
		send(F_S | 12'h0A2, 1'b1);
		send(F_P | 12'h0AA, 1'b1);
		send(F_S | 12'h0AA, 1'b0);
		chk(bbusy === 1'b1, "bus idle after start");
		send(12'h007, 1'b0);
		send(12'h0FE, 1'b0);
		w = n_wr;
		send(12'h011, 1'b0);
		send(12'h022, 1'b0);
		chk(n_wr === w, "written before stop");
		send(F_P | 12'h033, 1'b0);
		send(F_S | F_P | 12'h0AA, 1'b1);
		chk(wbusy === 1'b1, "no write cycle");
		wait_quiet(1'b1);
		chk(n_wr === w + 3 && mem[13'h07FE] === 8'h11 && mem[13'h07FF] === 8'h22, "page data");
		chk(mem[13'h07E0] === 8'h33, "page wrap");
		send(F_S | F_P | 12'h0AA, 1'b0);
		w = n_wr;
		wp <= 1'b1;
		send(F_S | 12'h0AA, 1'b0);
		send(12'h000, 1'b0);
		send(12'h010, 1'b0);
		send(F_P | 12'h055, 1'b0);
		wait_quiet(1'b0);
		// dropping protect after the stop must not revive the write
		wp <= 1'b0;
		send(F_S | 12'h0AB, 1'b0);
		cmd(F_RD | F_K | F_P, st);
		chk(st[7:0] === pat(13'h0011), "current read");
		chk(n_wr === w && wbusy === 1'b0 && mem[13'h0010] === pat(13'h0010), "protect");
		send(F_S | 12'h0AA, 1'b0);
		send(12'h01F, 1'b0);
		send(12'h005, 1'b0);
		send(F_S | 12'h0AB, 1'b0);
		cmd(F_RD, st);
		chk(st[7:0] === pat(13'h1F05), "random read");
		cmd(F_RD | F_K | F_P, st);
		chk(st[7:0] === pat(13'h1F06), "sequential read");
		chk(bbusy === 1'b0, "bus busy after stop");
		wait_quiet(1'b0);
		tally_and_finish();
	end
endmodule : i2c_memory_slave_frontend_bench
